// ---- noise_shaping_defines.vh ----
// Constants for the noise-shaping mode control block
// Function
// - One software-written control bit picks internal or external reference operation.
// - Noise shaping is off after reset and is switched on by its register bit or by any of the three mode pins.
// - Each 4-bit corner code selects a normalized corner, codes 0-7 giving 0.250-0.420 and 8-F 0.000-0.230.
// - The band center lies midway between the corners picked by the two corner codes.
// - While shaping is active, four sample cycles are added to the latency, 26 in total.
// - Shaping adds no group delay; only the fixed pipeline latency changes.
// - After a register write enables shaping, it is fully active 10 sample cycles after the write completes.
// - After shaping is disabled, unshaped data resumes 6 sample cycles later.
// - Without shaping, each output code appears 22 sample cycles after its sample is taken.
`ifndef NOISE_SHAPING_DEFINES_VH
`define NOISE_SHAPING_DEFINES_VH

// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CORNER 8'h08
`define ADDR_CENTER 8'h0C

// Control field positions
`define CTRL_REF_EXT 0
`define CTRL_SHAPE_EN 1
`define CTRL_CODE_A_LO 4
`define CTRL_CODE_B_LO 8
`define CTRL_RESET 12'h000

// Timing in sample cycles
`define LAT_PLAIN 5'h16
`define LAT_EXTRA 5'h04
`define ON_DELAY 4'hA
`define OFF_DELAY 4'h6

// Reference clocks per sample
`define SAMPLE_DIV 4'h2

// Sample and buffer sizes
`define SAMPLE_W 11
`define FIFO_DEPTH 4

`endif

// ---- sample_fifo.v ----
// Small synchronous FIFO with valid and ready on both sides
`default_nettype none
module sample_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst_n,
	// Fill side
	input wire i_in_valid,
	input wire [WIDTH-1:0] i_in_data,
	output reg o_in_ready,
	// Drain side
	output reg o_out_valid,
	output reg [WIDTH-1:0] o_out_data,
	input wire i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ff;
	reg [AW-1:0] rd_ff;
	reg [AW:0] cnt_ff;
	wire push;
	wire pop;
	wire [AW:0] nxt_cnt;

	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ff] <= i_in_data;
		end
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ff <= {AW{1'b0}};
			rd_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
			o_out_data <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
			cnt_ff <= nxt_cnt;
			o_in_ready <= (nxt_cnt != DEPTH[AW:0]);
			o_out_valid <= (nxt_cnt != {(AW+1){1'b0}});
			if (pop) begin
				if (cnt_ff == {{AW{1'b0}}, 1'b1} && push) begin
					o_out_data <= i_in_data;
				end else begin
					o_out_data <= mem[rd_ff + 1'b1];
				end
			end else if (cnt_ff == {(AW+1){1'b0}} && push) begin
				o_out_data <= i_in_data;
			end else begin
				o_out_data <= mem[rd_ff];
			end
		end
	end
endmodule // sample_fifo
`default_nettype wire

// ---- noise_shaping_ctrl.v ----
// Noise-shaping mode control with APB registers and latency pipeline
`include "noise_shaping_defines.vh"
`default_nettype none
module noise_shaping_ctrl (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst_n,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Mode pins
	input wire i_mode_pin_one,
	input wire i_mode_pin_two,
	input wire i_mode_pin_three,
	// Converter samples
	input wire [10:0] i_sample,
	// Mode outputs
	output reg o_ref_external,
	output reg o_shaping_active,
	// Capture side
	output reg [11:0] o_data,
	output reg o_data_valid,
	input wire i_data_ready,
	output reg o_overrun
);
	// Pin and sample synchronisers
	reg [2:0] pin_meta_ff;
	reg [2:0] pin_sync_ff;
	reg [10:0] smp_meta_ff;
	reg [10:0] smp_sync_ff;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta_ff <= 3'h0;
			pin_sync_ff <= 3'h0;
			smp_meta_ff <= 11'h000;
			smp_sync_ff <= 11'h000;
		end else begin
			pin_meta_ff <= {i_mode_pin_three, i_mode_pin_two, i_mode_pin_one};
			pin_sync_ff <= pin_meta_ff;
			smp_meta_ff <= i_sample;
			smp_sync_ff <= smp_meta_ff;
		end
	end

	// Sample clock enable divider
	reg [3:0] div_ff;
	reg smp_en_ff;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_ff <= 4'h0;
			smp_en_ff <= 1'b0;
		end else begin
			smp_en_ff <= (div_ff == `SAMPLE_DIV - 4'h1);
			if (div_ff == `SAMPLE_DIV - 4'h1) begin
				div_ff <= 4'h0;
			end else begin
				div_ff <= div_ff + 4'h1;
			end
		end
	end

	// Corner lookup in thousandths
	function [9:0] corner_of;
		input [3:0] code;
		begin
			case (code)
				4'h0: corner_of = 10'h0FA;
				4'h1: corner_of = 10'h10E;
				4'h2: corner_of = 10'h122;
				4'h3: corner_of = 10'h137;
				4'h4: corner_of = 10'h14D;
				4'h5: corner_of = 10'h165;
				4'h6: corner_of = 10'h181;
				4'h7: corner_of = 10'h1A4;
				4'h8: corner_of = 10'h000;
				4'h9: corner_of = 10'h050;
				4'hA: corner_of = 10'h073;
				4'hB: corner_of = 10'h08F;
				4'hC: corner_of = 10'h0A7;
				4'hD: corner_of = 10'h0BD;
				4'hE: corner_of = 10'h0D2;
				default: corner_of = 10'h0E6;
			endcase
		end
	endfunction

	// Control register
	reg [11:0] ctrl_ff;
	wire [3:0] code_a;
	wire [3:0] code_b;
	wire [9:0] corner_a;
	wire [9:0] corner_b;
	wire [10:0] center_x2;

	assign code_a = ctrl_ff[`CTRL_CODE_A_LO+3:`CTRL_CODE_A_LO];
	assign code_b = ctrl_ff[`CTRL_CODE_B_LO+3:`CTRL_CODE_B_LO];
	assign corner_a = corner_of(code_a);
	assign corner_b = corner_of(code_b);
	// Center in half-thousandths is the corner sum
	assign center_x2 = {1'b0, corner_a} + {1'b0, corner_b};

	// APB decode
	wire setup;
	wire access;
	wire wr_done;
	wire hit;

	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable & o_pready;
	assign hit = (i_paddr == `ADDR_CTRL) | (i_paddr == `ADDR_STATUS) |
		(i_paddr == `ADDR_CORNER) | (i_paddr == `ADDR_CENTER);
	assign wr_done = access & i_pwrite & ~o_pslverr & (i_paddr == `ADDR_CTRL);

	// Mode state machine
	localparam ST_OFF = 4'b0001;
	localparam ST_ARM = 4'b0010;
	localparam ST_ON = 4'b0100;
	localparam ST_DIS = 4'b1000;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [3:0] tick_ff;
	reg [3:0] nxt_tick;
	reg req_ff;
	reg nxt_active;
	wire req_now;

	// Register bit or any mode pin asks for shaping
	assign req_now = ctrl_ff[`CTRL_SHAPE_EN] | (|pin_sync_ff);

	always @* begin
		nxt_state = state_ff;
		nxt_tick = tick_ff;
		nxt_active = o_shaping_active;
		case (state_ff)
			ST_OFF: begin
				if (req_ff) begin
					nxt_state = ST_ARM;
					nxt_tick = `ON_DELAY;
				end
			end
			ST_ARM: begin
				if (!req_ff) begin
					nxt_state = ST_OFF;
				end else if (smp_en_ff) begin
					nxt_tick = tick_ff - 4'h1;
					if (tick_ff == 4'h1) begin
						nxt_state = ST_ON;
						nxt_active = 1'b1;
					end
				end
			end
			ST_ON: begin
				if (!req_ff) begin
					nxt_state = ST_DIS;
					nxt_tick = `OFF_DELAY;
				end
			end
			ST_DIS: begin
				if (smp_en_ff) begin
					nxt_tick = tick_ff - 4'h1;
					if (tick_ff == 4'h1) begin
						nxt_state = ST_OFF;
						nxt_active = 1'b0;
					end
				end
			end
			default: begin
				nxt_state = ST_OFF;
				nxt_active = 1'b0;
			end
		endcase
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_ff <= `CTRL_RESET;
			req_ff <= 1'b0;
			state_ff <= ST_OFF;
			tick_ff <= 4'h0;
			o_shaping_active <= 1'b0;
			o_ref_external <= 1'b0;
		end else begin
			if (wr_done) begin
				ctrl_ff <= i_pwdata[11:0];
			end
			req_ff <= req_now;
			state_ff <= nxt_state;
			tick_ff <= nxt_tick;
			o_shaping_active <= nxt_active;
			o_ref_external <= ctrl_ff[`CTRL_REF_EXT];
		end
	end

	// APB answer, one-cycle access phase
	reg [31:0] nxt_rdata;

	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (i_paddr)
			`ADDR_CTRL: nxt_rdata = {20'h00000, ctrl_ff};
			`ADDR_STATUS: nxt_rdata = {25'h0000000, o_overrun, o_ref_external,
				pin_sync_ff, (state_ff == ST_ARM) | (state_ff == ST_DIS), o_shaping_active};
			`ADDR_CORNER: nxt_rdata = {6'h00, corner_b, 6'h00, corner_a};
			`ADDR_CENTER: nxt_rdata = {21'h000000, center_x2};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			if (setup) begin
				o_prdata <= nxt_rdata;
				o_pslverr <= ~hit | (i_pwrite & (i_paddr != `ADDR_CTRL));
			end else begin
				o_pslverr <= 1'b0;
			end
		end
	end

	// Latency delay line, indexed by sample count
	reg [10:0] line_mem [0:31];
	reg [4:0] wp_ff;
	reg [4:0] fill_ff;
	reg [4:0] lat;
	reg push_ff;
	reg [11:0] push_data_ff;
	wire [4:0] rp;
	wire fifo_ready;
	wire fifo_valid;
	wire [11:0] fifo_data;

	// Only the pipeline depth changes with the mode, no filtering delay
	always @* begin
		lat = `LAT_PLAIN;
		if (o_shaping_active) begin
			lat = `LAT_PLAIN + `LAT_EXTRA;
		end
	end

	assign rp = wp_ff - lat;

	always @(posedge i_ref_clk) begin
		if (smp_en_ff) begin
			line_mem[wp_ff] <= smp_sync_ff;
		end
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_ff <= 5'h00;
			fill_ff <= 5'h00;
			push_ff <= 1'b0;
			push_data_ff <= 12'h000;
			o_overrun <= 1'b0;
		end else begin
			push_ff <= 1'b0;
			if (smp_en_ff) begin
				wp_ff <= wp_ff + 5'h01;
				if (fill_ff != 5'h1F) begin
					fill_ff <= fill_ff + 5'h01;
				end
				if (fill_ff >= lat) begin
					push_ff <= 1'b1;
					push_data_ff <= {o_shaping_active, line_mem[rp]};
				end
			end
			if (push_ff & ~fifo_ready) begin
				o_overrun <= 1'b1;
			end else if (wr_done) begin
				o_overrun <= 1'b0;
			end
		end
	end

	sample_fifo #(
		.WIDTH(12),
		.DEPTH(`FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_in_valid(push_ff),
		.i_in_data(push_data_ff),
		.o_in_ready(fifo_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(i_data_ready)
	);

	always @* begin
		o_data = fifo_data;
		o_data_valid = fifo_valid;
	end
endmodule // noise_shaping_ctrl
`default_nettype wire

// ---- noise_shaping_ctrl_properties.sv ----
// Port timing checker for the noise-shaping control
`default_nettype none
module noise_shaping_ctrl_properties (
	// Watched ports
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic i_mode_pin_one,
	input wire logic o_ref_external,
	input wire logic o_shaping_active,
	input wire logic [11:0] o_data,
	input wire logic o_data_valid,
	input wire logic i_data_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic wr;
	logic quiet;
	assign wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'h00;
	assign quiet = wr && !i_mode_pin_one;
	AST_REF_LAG: assert property (wr |-> ##2 o_ref_external == $past(i_pwdata[0], 2))
		else $error("ref select lag");
	AST_RESET_OFF: assert property ($rose(i_rst_n) |-> !o_shaping_active [*2])
		else $error("shaping on after reset");
	AST_ON_DELAY: assert property (quiet && i_pwdata[1] && !o_shaping_active
		|=> !o_shaping_active [*8] ##[10:16] o_shaping_active) else $error("on delay");
	AST_OFF_DELAY: assert property (quiet && !i_pwdata[1] && o_shaping_active
		|=> o_shaping_active [*8] ##[2:7] !o_shaping_active) else $error("off delay");
	AST_PIN_ON: assert property ($rose(i_mode_pin_one) && !o_shaping_active
		|=> !o_shaping_active [*8] ##[12:20] o_shaping_active) else $error("pin enable");
	AST_DATA_HOLD: assert property (o_data_valid && !i_data_ready
		|=> o_data_valid && $stable(o_data)) else $error("data dropped");
	AST_NO_EARLY: assert property ($rose(i_rst_n) |-> !o_data_valid [*8])
		else $error("data too early");
	AST_PREADY: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready");
endmodule // noise_shaping_ctrl_properties
`default_nettype wire

// ---- capture_sink.sv ----
// Capture-side model popping the delayed sample stream
`default_nettype none
module capture_sink (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Stream
	input wire logic [11:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	// Bench control
	input wire logic i_stall,
	input wire logic i_slow,
	output logic o_got,
	output logic [11:0] o_last
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ready <= 1'b0;
			o_got <= 1'b0;
			o_last <= 12'h000;
		end else begin
			o_ready <= !i_stall && !(i_slow && o_ready);
			o_got <= i_valid && o_ready;
			if (i_valid && o_ready)
				o_last <= i_data;
		end
	end
endmodule // capture_sink
`default_nettype wire

// ---- noise_shaping_ctrl_bench.sv ----
// Self-checking bench for the noise-shaping control
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module noise_shaping_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] TBL [16] = '{10'h0FA, 10'h10E, 10'h122, 10'h137, 10'h14D,
		10'h165, 10'h181, 10'h1A4, 10'h000, 10'h050, 10'h073, 10'h08F, 10'h0A7,
		10'h0BD, 10'h0D2, 10'h0E6};
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 0, slow = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rdata, prdata;
	logic pready, pslverr, rerr, ref_ext, act, valid, ready, ovr, got;
	logic [2:0] pins = 3'h0;
	logic [10:0] smp = 11'h000;
	logic [11:0] data, last;
	logic [3:0] b;
	int fail_count = 0, n_tests = 0, cycles = 0, t;
	initial forever #5 clk = ~clk;
	noise_shaping_ctrl dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mode_pin_one(pins[0]),
		.i_mode_pin_two(pins[1]), .i_mode_pin_three(pins[2]), .i_sample(smp),
		.o_ref_external(ref_ext), .o_shaping_active(act), .o_data(data), .o_data_valid(valid),
		.i_data_ready(ready), .o_overrun(ovr));
	capture_sink sink_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_data(data), .i_valid(valid),
		.o_ready(ready), .i_stall(stall), .i_slow(slow), .o_got(got), .o_last(last));
	function automatic logic [31:0] center(input logic [3:0] a, input logic [3:0] c);
		return 32'(TBL[a]) + 32'(TBL[c]);
	endfunction
	task results;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_act(input logic want, input int lo, input int hi);
		t = 0;
		while (act !== want && t < 60) begin
			@(posedge clk);
			t++;
		end
		`CHK("switch time", 1'b1, t >= lo && t <= hi)
	endtask
	task automatic lat(input logic flag, input int lo, input int hi);
		logic [10:0] m;
		m = 11'($urandom);
		smp <= ~m;
		repeat (70) @(posedge clk);
		smp <= m;
		t = 0;
		while (!(got && last[10:0] === m) && t < 100) begin
			@(posedge clk);
			t++;
		end
		`CHK("latency", 1'b1, t >= lo && t <= hi)
		`CHK("shaped flag", flag, last[11])
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		t = $urandom(32'hEA19);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, 8'h00, 0);
		`CHK("ctrl reset", 32'h0, rdata)
		apb(0, 8'h04, 0);
		`CHK("active reset", 1'b0, rdata[0])
		apb(1, 8'h00, 1);
		apb(0, 8'h00, 0);
		`CHK("ref bit", 32'h1, rdata)
		`CHK("ref pin", 1'b1, ref_ext)
		apb(1, 8'h00, 0);
		repeat (2) @(posedge clk);
		`CHK("ref pin", 1'b0, ref_ext)
		for (int k = 0; k < 16; k++) begin
			b = 4'($urandom_range(15));
			apb(1, 8'h00, {20'h0, b, 4'(k), 4'h0});
			apb(0, 8'h08, 0);
			`CHK("corners", {6'h00, TBL[b], 6'h00, TBL[k]}, rdata)
			apb(0, 8'h0C, 0);
			`CHK("center", center(4'(k), b), rdata)
		end
		apb(0, 8'h10, 0);
		`CHK("unmapped", 33'h1_0000_0000, {rerr, rdata})
		apb(1, 8'h04, 32'hFFFFFFFF);
		`CHK("ro write", 1'b1, rerr)
		lat(1'b0, 44, 51);
		apb(1, 8'h00, 2);
		wait_act(1'b1, 18, 27);
		lat(1'b1, 52, 59);
		apb(1, 8'h00, 0);
		wait_act(1'b0, 9, 17);
		for (int p = 0; p < 3; p++) begin
			pins <= 3'h1 << p;
			wait_act(1'b1, 19, 31);
			apb(0, 8'h04, 0);
			`CHK("pins seen", pins, rdata[4:2])
			pins <= 3'h0;
			wait_act(1'b0, 9, 20);
		end
		stall <= 1'b1;
		repeat (40) @(posedge clk);
		`CHK("overrun", 2'h3, {valid, ovr})
		stall <= 1'b0;
		slow <= 1'b1;
		repeat (30) @(posedge clk);
		slow <= 1'b0;
		apb(1, 8'h00, 0);
		repeat (2) @(posedge clk);
		`CHK("overrun clear", 1'b0, ovr)
		results();
	end
endmodule // noise_shaping_ctrl_bench
bind noise_shaping_ctrl noise_shaping_ctrl_properties chk_u (.i_ref_clk, .i_rst_n, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .i_mode_pin_one, .o_ref_external,
	.o_shaping_active, .o_data, .o_data_valid, .i_data_ready);
`default_nettype wire
